//--- hdl/dsw_guard.sv
// disk drive main-board seek and write guard, with an apb register slave
// assumes every pin input is synchronous to i_clk and reset is power-on only
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module dsw_guard #(
	parameter int unsigned MASK_CYCLES = dsw_pkg::MASK_CYCLES,
	parameter int unsigned HEADS = dsw_pkg::HEADS_FITTED
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// seek control from the host
	input wire logic i_step,
	input wire logic i_dir_in,
	// read and write control from the host
	input wire logic [2:0] i_head_sel,
	input wire logic i_write_gate_n,
	input wire logic i_write_protect,
	input wire logic i_write_data,
	// drive sensors
	input wire logic i_index,
	input wire logic i_track_phase,
	input wire logic i_wr_fault_sense,
	input wire logic [7:0] i_burst_a,
	input wire logic [7:0] i_burst_b,
	input wire logic i_final_image,
	// servo outputs
	output logic o_pos_mode,
	output logic o_motor_dir,
	output logic o_seek_complete,
	output logic o_trim_en,
	output logic o_trim_dir,
	// head and write path outputs
	output logic [2:0] o_read_head,
	output logic [2:0] o_write_head,
	output logic o_write_amp_en,
	output logic o_write_data,
	output logic o_write_disable,
	output logic o_servo_mask,
	output logic o_write_fault,
	// interrupt
	output logic o_irq
);
	////////////////////////////////////////////////////////////////////////
	// types and state

	localparam int unsigned CW = dsw_pkg::CNT_W;
	localparam int unsigned IW = dsw_pkg::IRQ_W;
	localparam int unsigned FW = dsw_pkg::FC_W;

	// one packed struct holds every register of the top; r_next is its next value
	typedef struct packed {
		logic step_q;
		logic phase_q;
		logic seek_cpl;
		logic fault;
		logic [FW-1:0] cause;
		logic amp_en;
		logic wr_data;
		logic [2:0] rd_head;
		logic [2:0] wr_head;
		logic trim_en;
		logic trim_dir;
		logic [dsw_pkg::CTRL_W-1:0] ctrl;
		logic [IW-1:0] irq_stat;
		logic [IW-1:0] irq_mask;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dsw_guard_s;

	dsw_guard_s r_reg;
	dsw_guard_s r_next;

	logic mask_win;
	logic mask_now;
	logic setup;
	logic wr_acc;
	logic fault_gate;
	logic fault_head;
	logic [FW-1:0] cause_new;
	logic [IW-1:0] events;
	logic [IW-1:0] w1c;
	logic [31:0] status_word;

	// the sequencer keeps its own state; the top only feeds it edges, the direction and the total clear,
	// and reads back gain, busy, done, direction and counts, so the seek path stands on its own
	dsw_seek_if #(.CNT_W(CW)) sk ();

	////////////////////////////////////////////////////////////////////////
	// address decode

	// register map, one aligned 32-bit word each:
	//   0x00 control: bit 0 burst correction enable, bit 1 clears the step total
	//   0x04 status, read only: gain mode, busy, fault, mask, trim, pending tracks
	//   0x08 interrupt status, write one to clear; a new event wins over a clear
	//   0x0c interrupt mask, same layout as the interrupt status
	//   0x10 fault causes, sticky, with the step total in the upper half
	// anything else answers with an error response and reads as zero
	// true for every register offset the slave answers
	function automatic logic is_mapped(input logic [7:0] addr);
		case (addr)
			dsw_pkg::OFF_CTRL,
			dsw_pkg::OFF_STATUS,
			dsw_pkg::OFF_IRQ_STAT,
			dsw_pkg::OFF_IRQ_MASK,
			dsw_pkg::OFF_FAULT: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// submodules

	// servo mask window, retriggered by each index pulse
	dsw_mask_timer #(
		.CYCLES(MASK_CYCLES)
	) u_mask (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_index(i_index),
		.o_mask(mask_win)
	);

	// step counting and gain selection
	dsw_seek_seq u_seek (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.sk(sk.seq)
	);

	// events toward the sequencer, edge detected so a long pulse counts once
	assign sk.step = i_step & ~r_reg.step_q;
	assign sk.dir_in = i_dir_in;
	assign sk.boundary = i_track_phase ^ r_reg.phase_q;
	assign sk.clr_total = wr_acc && i_paddr == dsw_pkg::OFF_CTRL &&
		i_pwdata[dsw_pkg::CTRL_STEP_CNT_CLR];

	////////////////////////////////////////////////////////////////////////
	// write fault detection

	// the index pulse itself closes the amplifier, the timer holds it after
	assign mask_now = mask_win | i_index;

	// write data while the gate reads high, including a floating gate
	assign fault_gate = i_write_data & i_write_gate_n;

	// write attempt on a head beyond those fitted
	assign fault_head = i_write_data & ~i_write_gate_n &
		({1'b0, i_head_sel} >= 4'(HEADS));

	// one bit per source, so software can tell a head fault from a gate fault
	// cause bits in fixed positions for the fault register
	always_comb begin
		cause_new = '0;
		cause_new[dsw_pkg::FC_SENSE] = i_wr_fault_sense;
		cause_new[dsw_pkg::FC_GATE] = fault_gate;
		cause_new[dsw_pkg::FC_HEAD] = fault_head;
	end

	////////////////////////////////////////////////////////////////////////
	// bus phase decode

	assign setup = i_psel & ~i_penable;
	// a write lands only at the completing access edge
	assign wr_acc = i_psel & i_penable & i_pwrite & r_reg.pready &
		is_mapped(i_paddr);

	// status word sampled in the setup cycle of a read
	always_comb begin
		status_word = '0;
		status_word[dsw_pkg::ST_POS_MODE] = sk.pos_mode;
		status_word[dsw_pkg::ST_BUSY] = sk.busy;
		status_word[dsw_pkg::ST_FAULT] = r_reg.fault;
		status_word[dsw_pkg::ST_MASK] = mask_win;
		status_word[dsw_pkg::ST_TRIM] = r_reg.trim_en;
		status_word[dsw_pkg::ST_TRIM_DIR] = r_reg.trim_dir;
		status_word[dsw_pkg::ST_CNT_LSB +: CW] = sk.pending;
	end

	// interrupt sources, each a single-cycle event
	always_comb begin
		events = '0;
		events[dsw_pkg::IRQ_SEEK_DONE] = sk.done;
		events[dsw_pkg::IRQ_WR_FAULT] = (|cause_new) & ~r_reg.fault;
		events[dsw_pkg::IRQ_INDEX] = i_index;
	end

	// write-one-to-clear strobes for the interrupt status
	assign w1c = (wr_acc && i_paddr == dsw_pkg::OFF_IRQ_STAT) ?
		i_pwdata[IW-1:0] : '0;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		r_next = r_reg;
		r_next.step_q = i_step;
		r_next.phase_q = i_track_phase;
		// seek complete trails busy by one edge so the pin is a plain register;
		// the gain line has already settled when a polling host sees it
		r_next.seek_cpl = ~sk.busy;

		// fault latch: no input clears it, only power-on reset
		r_next.cause = r_reg.cause | cause_new;
		r_next.fault = r_reg.fault | (|cause_new);

		// amplifier off on disable, mask or protect low; data gated on the
		// same edge, so nothing reaches the head once a condition is seen
		r_next.amp_en = ~r_next.fault & ~mask_now & i_write_protect &
			~i_write_gate_n;
		r_next.wr_data = i_write_data & r_next.amp_en;
		r_next.wr_head = i_head_sel;

		// head choice: host lines ignored inside the window; the live phase is
		// used, not phase_q, so the head follows the crossing on the next edge
		if (mask_now) begin
			r_next.rd_head = {2'h0, ~i_track_phase};
		end else begin
			r_next.rd_head = i_head_sel;
		end

		// burst correction only when parked, enabled and the final image runs
		// trimming during a seek would fight the velocity loop, so it waits
		r_next.trim_en = r_reg.ctrl[dsw_pkg::CTRL_BURST_EN] & i_final_image &
			~sk.busy & (i_burst_a != i_burst_b);
		r_next.trim_dir = (i_burst_a < i_burst_b);

		// interrupt status: a set in the clearing cycle wins
		r_next.irq_stat = (r_reg.irq_stat & ~w1c) | events;

		// register writes
		if (wr_acc) begin
			case (i_paddr)
				dsw_pkg::OFF_CTRL: begin
					r_next.ctrl = i_pwdata[dsw_pkg::CTRL_W-1:0];
					r_next.ctrl[dsw_pkg::CTRL_STEP_CNT_CLR] = 1'b0;
				end
				dsw_pkg::OFF_IRQ_MASK: begin
					r_next.irq_mask = i_pwdata[IW-1:0];
				end
				default: begin
					r_next.ctrl = r_reg.ctrl;
				end
			endcase
		end

		// next status and mask are used so the line rises with the status bit
		r_next.irq = |(r_next.irq_stat & r_next.irq_mask);

		// answer in the cycle after setup, so every access has one wait-free
		// access phase; read data is captured at setup and then held
		r_next.pready = setup;
		// a miss gets an error instead of a hang, so a stray access costs one
		// cycle and changes nothing
		r_next.pslverr = setup & ~is_mapped(i_paddr);
		if (setup && !i_pwrite) begin
			case (i_paddr)
				dsw_pkg::OFF_CTRL: begin
					r_next.prdata = {30'h0, r_reg.ctrl};
				end
				dsw_pkg::OFF_STATUS: begin
					r_next.prdata = status_word;
				end
				dsw_pkg::OFF_IRQ_STAT: begin
					r_next.prdata = {29'h0, r_reg.irq_stat};
				end
				dsw_pkg::OFF_IRQ_MASK: begin
					r_next.prdata = {29'h0, r_reg.irq_mask};
				end
				dsw_pkg::OFF_FAULT: begin
					r_next.prdata = {{(32-CW){1'b0}}, sk.total} << 16 |
						{29'h0, r_reg.cause};
				end
				default: begin
					r_next.prdata = '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	// power-on reset is the only clear the fault latch ever sees
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_reg <= '0;
			r_reg.seek_cpl <= 1'b1;
			r_reg.ctrl <= dsw_pkg::CTRL_RST;
			r_reg.irq_mask <= dsw_pkg::IRQ_MASK_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, each from a flip-flop
	// no output passes through decode, so the host never sees a glitch

	assign o_prdata = r_reg.prdata;
	assign o_pready = r_reg.pready;
	assign o_pslverr = r_reg.pslverr;
	assign o_pos_mode = sk.pos_mode;
	assign o_motor_dir = sk.motor_dir;
	assign o_seek_complete = r_reg.seek_cpl;
	assign o_trim_en = r_reg.trim_en;
	assign o_trim_dir = r_reg.trim_dir;
	assign o_read_head = r_reg.rd_head;
	assign o_write_head = r_reg.wr_head;
	assign o_write_amp_en = r_reg.amp_en;
	assign o_write_data = r_reg.wr_data;
	assign o_write_disable = r_reg.fault;
	assign o_servo_mask = mask_win;
	assign o_write_fault = r_reg.fault;
	assign o_irq = r_reg.irq;
endmodule

//--- hdl/dsw_mask_timer.sv
// servo mask window timer, restarted by every spindle index
// assumes the index input is a one-cycle pulse synchronous to the clock
`timescale 1ns/1ps
module dsw_mask_timer #(
	parameter int unsigned CYCLES = dsw_pkg::MASK_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// index event and window
	input wire logic i_index,
	output logic o_mask
);
	localparam int unsigned TW = $clog2(CYCLES + 1);
	typedef struct packed {
		logic [TW-1:0] cnt;
		logic mask;
	} dsw_mt_s;
	dsw_mt_s r_reg;
	dsw_mt_s r_next;

	// window opens on index and closes after the programmed count
	always_comb begin
		r_next = r_reg;
		if (i_index) begin
			r_next.cnt = TW'(1);
			r_next.mask = 1'b1;
		end else if (r_reg.mask) begin
			r_next.cnt = r_reg.cnt + TW'(1);
			r_next.mask = (r_reg.cnt < TW'(CYCLES));
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_mask = r_reg.mask;
endmodule

//--- hdl/dsw_seek_seq.sv
// seek sequencer: counts steps in, track boundaries out, picks servo gain
// assumes step and boundary are single-cycle events from the top
`timescale 1ns/1ps
module dsw_seek_seq (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// link to the guard top
	dsw_seek_if.seq sk
);
	localparam int unsigned CW = dsw_pkg::CNT_W;
	typedef struct packed {
		dsw_pkg::dsw_seek_e state;
		logic [CW-1:0] pending;
		logic [CW-1:0] total;
		logic dir;
		logic done;
		logic pos_mode;
		logic busy;
	} dsw_sk_s;
	dsw_sk_s r_reg;
	dsw_sk_s r_next;
	logic [CW-1:0] cnt;

	// a step and a boundary in one cycle cancel outside idle and below full; count saturates at full
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		cnt = r_reg.pending;
		if (sk.step && !(&cnt)) begin
			cnt = cnt + CW'(1);
		end
		if (sk.boundary && r_reg.state != dsw_pkg::SK_IDLE && cnt != '0) begin
			cnt = cnt - CW'(1);
		end
		if (sk.step && r_reg.state == dsw_pkg::SK_IDLE) begin
			r_next.dir = sk.dir_in;
		end
		if (sk.clr_total) begin
			r_next.total = '0;
		end else if (sk.step && !(&r_reg.total)) begin
			r_next.total = r_reg.total + CW'(1);
		end
		r_next.pending = cnt;
		case (r_reg.state)
			dsw_pkg::SK_IDLE, dsw_pkg::SK_VEL, dsw_pkg::SK_POS: begin
				if (cnt == '0) begin
					r_next.state = dsw_pkg::SK_IDLE;
					r_next.done = (r_reg.state != dsw_pkg::SK_IDLE);
				end else if (cnt == CW'(1)) begin
					r_next.state = dsw_pkg::SK_POS;
				end else begin
					r_next.state = dsw_pkg::SK_VEL;
				end
			end
			default: begin
				r_next.state = dsw_pkg::SK_IDLE;
			end
		endcase
		// gain and busy registered from the next state, so pins see no decode
		r_next.pos_mode = (r_next.state != dsw_pkg::SK_VEL);
		r_next.busy = (r_next.state != dsw_pkg::SK_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_reg.state <= dsw_pkg::SK_IDLE;
			r_reg.pending <= '0;
			r_reg.total <= '0;
			r_reg.dir <= 1'b0;
			r_reg.done <= 1'b0;
			r_reg.pos_mode <= 1'b1;
			r_reg.busy <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	// low gain everywhere but velocity operation
	assign sk.pos_mode = r_reg.pos_mode;
	assign sk.busy = r_reg.busy;
	assign sk.done = r_reg.done;
	assign sk.motor_dir = r_reg.dir;
	assign sk.pending = r_reg.pending;
	assign sk.total = r_reg.total;
endmodule

//--- pkg/dsw_pkg.sv
// shared constants and types for the disk seek and write guard block
// assumes a single 125 MHz clock and an apb slave with 32-bit data
package dsw_pkg;
	// clock rate and timing figures
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned MASK_TIME_US = 128;
	localparam int unsigned MASK_CYCLES = MASK_TIME_US * CLK_MHZ;
	localparam int unsigned STEP_GAP_US = 25;
	localparam int unsigned STEP_GAP_CYCLES = STEP_GAP_US * CLK_MHZ;
	// drive geometry and counter widths
	localparam int unsigned HEADS_FITTED = 4;
	localparam int unsigned CNT_W = 12;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFF_FAULT = 8'h10;
	// control field positions and reset values
	localparam int unsigned CTRL_BURST_EN = 0;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam int unsigned CTRL_W = 2;
	localparam int unsigned CTRL_STEP_CNT_CLR = 1;
	// status field positions
	localparam int unsigned ST_POS_MODE = 0;
	localparam int unsigned ST_BUSY = 1;
	localparam int unsigned ST_FAULT = 2;
	localparam int unsigned ST_MASK = 3;
	localparam int unsigned ST_TRIM = 4;
	localparam int unsigned ST_TRIM_DIR = 5;
	localparam int unsigned ST_CNT_LSB = 16;
	// interrupt field positions, shared by status and mask
	localparam int unsigned IRQ_SEEK_DONE = 0;
	localparam int unsigned IRQ_WR_FAULT = 1;
	localparam int unsigned IRQ_INDEX = 2;
	localparam int unsigned IRQ_W = 3;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	// fault cause field positions
	localparam int unsigned FC_SENSE = 0;
	localparam int unsigned FC_GATE = 1;
	localparam int unsigned FC_HEAD = 2;
	localparam int unsigned FC_W = 3;
	// seek sequencer states
	typedef enum logic [2:0] {
		SK_IDLE = 3'h1,
		SK_VEL = 3'h2,
		SK_POS = 3'h4
	} dsw_seek_e;
endpackage

//--- pkg/dsw_seek_if.sv
// signals between the guard top and its seek sequencer
// assumes one clock domain; the top drives the events, the sequencer the rest
`timescale 1ns/1ps
interface dsw_seek_if #(parameter int unsigned CNT_W = dsw_pkg::CNT_W);
	logic step;
	logic dir_in;
	logic boundary;
	logic pos_mode;
	logic busy;
	logic done;
	logic motor_dir;
	logic [CNT_W-1:0] pending;
	logic [CNT_W-1:0] total;
	logic clr_total;
	modport seq (input step, dir_in, boundary, clr_total,
		output pos_mode, busy, done, motor_dir, pending, total);
	modport user (output step, dir_in, boundary, clr_total,
		input pos_mode, busy, done, motor_dir, pending, total);
endinterface

//--- sim/dsw_guard_assertions.sv
// port-level checker for the seek and write guard
// assumes it is bound into dsw_guard and shares its single clock
`timescale 1ns/1ps
module dsw_guard_chk #(
	parameter int unsigned MASK_CYCLES = 20,
	parameter int unsigned HEADS = 4
) (
	// clock, reset and apb
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	// host and sensor inputs
	input wire logic [2:0] i_head_sel,
	input wire logic i_write_gate_n,
	input wire logic i_write_protect,
	input wire logic i_write_data,
	input wire logic i_index,
	input wire logic i_track_phase,
	input wire logic i_wr_fault_sense,
	// outputs watched
	input wire logic o_pos_mode,
	input wire logic o_seek_complete,
	input wire logic [2:0] o_read_head,
	input wire logic o_write_amp_en,
	input wire logic o_write_data,
	input wire logic o_write_disable,
	input wire logic o_servo_mask,
	input wire logic o_write_fault
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic [31:0] win_reg;
	////////////////////////////////////////////////////////////////////////////////
	// cycles since the last index, parked at the window length when idle
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) win_reg <= MASK_CYCLES;
		else if (i_index) win_reg <= 32'h0;
		else if (win_reg < MASK_CYCLES) win_reg <= win_reg + 32'h1;
	end
	////////////////////////////////////////////////////////////////////////////////
	a_apb_ready: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
		else $error("apb answer not one cycle after setup");
	a_mask_len: assert property (o_servo_mask == (win_reg < MASK_CYCLES))
		else $error("mask window length wrong");
	a_amp_block: assert property (!i_write_protect || i_index || i_write_gate_n |=> !o_write_amp_en)
		else $error("write amp on while blocked");
	a_mask_amp: assert property (o_servo_mask |-> !o_write_amp_en)
		else $error("write amp on in mask window");
	a_mask_head: assert property ($past(o_servo_mask) && o_servo_mask
		|-> o_read_head == {2'h0, !$past(i_track_phase)})
		else $error("read head not forced in mask window");
	a_sense_fault: assert property (i_wr_fault_sense |=> o_write_fault)
		else $error("sensed fault not latched");
	a_fault_off: assert property (o_write_fault |-> o_write_disable && !o_write_amp_en)
		else $error("fault without write disable");
	a_fault_sticky: assert property (o_write_fault |=> o_write_fault)
		else $error("fault cleared without reset");
	a_gate_fault: assert property (i_write_data && i_write_gate_n |=> o_write_fault)
		else $error("data with gate high not faulted");
	a_head_fault: assert property (i_write_data && !i_write_gate_n && i_head_sel >= HEADS
		|=> o_write_fault)
		else $error("write on missing head not faulted");
	a_data_gate: assert property (!o_write_amp_en |-> !o_write_data)
		else $error("write data passes with amp off");
	a_idle_pos: assert property (o_seek_complete |-> o_pos_mode)
		else $error("idle not in position mode");
endmodule
bind dsw_guard dsw_guard_chk #(.MASK_CYCLES(MASK_CYCLES), .HEADS(HEADS)) u_chk (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
	.o_pready(o_pready), .i_head_sel(i_head_sel), .i_write_gate_n(i_write_gate_n),
	.i_write_protect(i_write_protect), .i_write_data(i_write_data), .i_index(i_index),
	.i_track_phase(i_track_phase), .i_wr_fault_sense(i_wr_fault_sense),
	.o_pos_mode(o_pos_mode), .o_seek_complete(o_seek_complete), .o_read_head(o_read_head),
	.o_write_amp_en(o_write_amp_en), .o_write_data(o_write_data),
	.o_write_disable(o_write_disable), .o_servo_mask(o_servo_mask),
	.o_write_fault(o_write_fault));

//--- sim/dsw_host_model.sv
// host controller model: issues a burst of seek step pulses on request
// assumes the bench raises i_go for one cycle and waits for o_busy to fall
`timescale 1ns/1ps
module dsw_host_model (
	// clock and request
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [7:0] i_count,
	input wire logic [15:0] i_gap,
	// step line and status
	output logic o_step,
	output logic o_busy
);
	// each step stays high two cycles so a slow edge detector still sees it
	initial begin
		o_step = 1'b0;
		o_busy = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_go) begin
				o_busy <= 1'b1;
				for (int n = 0; n < i_count; n++) begin
					o_step <= 1'b1;
					repeat (2) @(posedge i_clk);
					o_step <= 1'b0;
					repeat (i_gap - 16'h2) @(posedge i_clk);
				end
				o_busy <= 1'b0;
			end
		end
	end
endmodule

//--- sim/testbench.sv
// self-checking bench for dsw_guard: apb registers, seek, write path, faults
// assumes the host model drives steps; the bench drives all other pins
`timescale 1ns/1ps
module testbench;
	localparam int unsigned MASK = 20;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, step, dir_in, gate_n, protect;
	logic wdata, index, phase, sense, final_img, go, host_busy, rd_err;
	logic pos_mode, motor_dir, seek_cpl, trim_en, trim_dir, amp_en, wdata_o, wr_dis, mask;
	logic wr_fault, irq;
	logic [7:0] paddr, burst_a, burst_b;
	logic [31:0] pwdata, prdata, rd_q;
	logic [2:0] head_sel, read_head, write_head;
	int bad_count = 0;
	int cmp_count = 0;
	dsw_guard #(.MASK_CYCLES(MASK), .HEADS(4)) dut (.i_clk(clk), .i_rstn(rstn),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_step(step), .i_dir_in(dir_in), .i_head_sel(head_sel), .i_write_gate_n(gate_n),
		.i_write_protect(protect), .i_write_data(wdata), .i_index(index),
		.i_track_phase(phase), .i_wr_fault_sense(sense), .i_burst_a(burst_a),
		.i_burst_b(burst_b), .i_final_image(final_img), .o_pos_mode(pos_mode),
		.o_motor_dir(motor_dir), .o_seek_complete(seek_cpl), .o_trim_en(trim_en),
		.o_trim_dir(trim_dir), .o_read_head(read_head), .o_write_head(write_head),
		.o_write_amp_en(amp_en), .o_write_data(wdata_o), .o_write_disable(wr_dis),
		.o_servo_mask(mask), .o_write_fault(wr_fault), .o_irq(irq));
	dsw_host_model host (.i_clk(clk), .i_go(go), .i_count(8'h05),
		.i_gap(16'(dsw_pkg::STEP_GAP_CYCLES)), .o_step(step), .o_busy(host_busy));
	////////////////////////////////////////////////////////////////////////////////
	// common tasks
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; the wait for pready is bounded
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 8) begin
			bad_count++;
			end_of_test;
		end
		rd_q = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset;
		rstn <= 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset_vals;
		chk(pos_mode, 32'h1);
		chk(seek_cpl, 32'h1);
		chk(irq, 32'h0);
		apb(1'b0, dsw_pkg::OFF_IRQ_MASK, 32'h0);
		chk(rd_q, 32'h0);
		apb(1'b0, dsw_pkg::OFF_CTRL, 32'h0);
		chk(rd_q, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({rd_err, rd_q[30:0]}, 32'h80000000);
	endtask
	// five steps, then five boundaries; gain drops to position mode at one track left
	task automatic t_seek;
		int n;
		dir_in <= 1'b1;
		apb(1'b1, dsw_pkg::OFF_IRQ_STAT, 32'h7);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (n = 0; n < 20000; n++) begin
			@(posedge clk);
			if (host_busy === 1'b0) break;
		end
		if (n == 20000) begin
			bad_count++;
			end_of_test;
		end
		repeat (4) @(posedge clk);
		apb(1'b0, dsw_pkg::OFF_STATUS, 32'h0);
		chk(rd_q[27:16], 32'h5);
		chk(motor_dir, 32'h1);
		for (int k = 1; k <= 5; k++) begin
			phase <= ~phase;
			repeat (4) @(posedge clk);
			chk(pos_mode, (5 - k) < 2);
			apb(1'b0, dsw_pkg::OFF_STATUS, 32'h0);
			chk(rd_q[27:16], 5 - k);
		end
		chk(seek_cpl, 32'h1);
		apb(1'b0, dsw_pkg::OFF_FAULT, 32'h0);
		chk(rd_q[27:16], 32'h5);
		chk(irq, 32'h0);
		apb(1'b1, dsw_pkg::OFF_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 32'h1);
		apb(1'b1, dsw_pkg::OFF_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 32'h0);
	endtask
	// legal write, protect drop, then a mask window forcing the read head
	task automatic t_write;
		head_sel <= 3'h1;
		gate_n <= 1'b0;
		protect <= 1'b1;
		wdata <= 1'b1;
		repeat (3) @(posedge clk);
		chk({amp_en, wdata_o, write_head}, 32'h19);
		protect <= 1'b0;
		repeat (2) @(posedge clk);
		chk({amp_en, wdata_o}, 32'h0);
		protect <= 1'b1;
		head_sel <= 3'h3;
		phase <= 1'b1;
		index <= 1'b1;
		@(posedge clk);
		index <= 1'b0;
		repeat (3) @(posedge clk);
		chk({mask, amp_en, read_head}, 32'h10);
		phase <= 1'b0;
		repeat (3) @(posedge clk);
		chk(read_head, 32'h1);
		repeat (MASK) @(posedge clk);
		chk(mask, 32'h0);
		repeat (2) @(posedge clk);
		chk({amp_en, read_head}, 32'hb);
		apb(1'b0, dsw_pkg::OFF_IRQ_STAT, 32'h0);
		chk(rd_q[2], 32'h1);
		wdata <= 1'b0;
	endtask
	task automatic t_trim;
		burst_a <= 8'h10;
		burst_b <= 8'h20;
		final_img <= 1'b1;
		apb(1'b1, dsw_pkg::OFF_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		chk({trim_en, trim_dir}, 32'h3);
		final_img <= 1'b0;
		repeat (4) @(posedge clk);
		chk(trim_en, 32'h0);
		final_img <= 1'b1;
		burst_b <= 8'h10;
		repeat (4) @(posedge clk);
		chk(trim_en, 32'h0);
	endtask
	// k selects the cause: sensed fault, data with gate high, missing head
	task automatic t_fault(input int k);
		if (k == 0) sense <= 1'b1;
		if (k == 1) gate_n <= 1'b1;
		if (k == 2) head_sel <= 3'h5;
		if (k > 0) wdata <= 1'b1;
		repeat (3) @(posedge clk);
		chk({wr_fault, wr_dis, amp_en}, 32'h6);
		apb(1'b0, dsw_pkg::OFF_FAULT, 32'h0);
		chk(rd_q[2:0], 3'h1 << k);
		apb(1'b0, dsw_pkg::OFF_IRQ_STAT, 32'h0);
		chk(rd_q[1], 32'h1);
		sense <= 1'b0;
		gate_n <= 1'b0;
		wdata <= 1'b0;
		head_sel <= 3'h0;
		apb(1'b1, dsw_pkg::OFF_IRQ_STAT, 32'h7);
		apb(1'b1, dsw_pkg::OFF_CTRL, 32'h2);
		repeat (4) @(posedge clk);
		chk(wr_fault, 32'h1);
		do_reset;
		chk(wr_fault, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// clock and main sequence
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rstn, psel, penable, pwrite, dir_in, protect, wdata, index, phase} = 9'h0;
		{sense, final_img, go, head_sel, paddr, pwdata, burst_a, burst_b} = 62'h0;
		gate_n = 1'b1;
		do_reset;
		t_reset_vals;
		t_seek;
		t_write;
		t_trim;
		for (int k = 0; k < 3; k++) t_fault(k);
		end_of_test;
	end
endmodule
